/* File: core/rtc_pkg.sv */
// constants for the clock, calendar, alarm and tamper block
package rtc_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_SEC      = 8'h00;
    localparam logic [7:0] ADDR_MIN      = 8'h04;
    localparam logic [7:0] ADDR_HOUR     = 8'h08;
    localparam logic [7:0] ADDR_DATE     = 8'h0C;
    localparam logic [7:0] ADDR_MONTH    = 8'h10;
    localparam logic [7:0] ADDR_YEAR     = 8'h14;
    localparam logic [7:0] ADDR_WDAY     = 8'h18;
    localparam logic [7:0] ADDR_STATUS   = 8'h1C;
    localparam logic [7:0] ADDR_CTRL     = 8'h20;
    localparam logic [7:0] ADDR_ALM_EN   = 8'h24;
    localparam logic [7:0] ADDR_ALM_TIME = 8'h28;
    localparam logic [7:0] ADDR_ALM_DATE = 8'h2C;
    localparam logic [7:0] ADDR_TS_TIME  = 8'h30;
    localparam logic [7:0] ADDR_TS_DATE  = 8'h34;
    // status bits
    localparam int ST_ALARM  = 0;
    localparam int ST_EVENT  = 1;
    localparam int ST_FAIL   = 2;
    localparam int ST_BACKUP = 3;
    // control fields
    localparam int CT_EVT_EN   = 0;
    localparam int CT_EVT_BAT  = 1;
    localparam int CT_FREEZE   = 2;
    localparam int CT_DET_OUT  = 3;
    localparam int CT_FILT_LO  = 4;
    localparam int CT_SMP_LO   = 6;
    localparam int CT_IRQ_EN   = 8;
    localparam int CT_REPEAT   = 9;
    localparam int CT_FREQ_LO  = 10;
    localparam int CT_W        = 14;
    localparam logic [13:0] CTRL_RESET = 14'h0000;
    // packed time and date field positions
    localparam int TF_SEC  = 0;
    localparam int TF_MIN  = 8;
    localparam int TF_HOUR = 16;
    localparam int DF_DATE = 0;
    localparam int DF_MON  = 8;
    localparam int DF_WDAY = 16;
    localparam int DF_YEAR = 24;
    // alarm enable bits
    localparam int AE_SEC  = 0;
    localparam int AE_MIN  = 1;
    localparam int AE_HOUR = 2;
    localparam int AE_DATE = 3;
    localparam int AE_MON  = 4;
    localparam int AE_WDAY = 5;
    // timebase
    localparam int unsigned CRYSTAL_HZ = 32768;
    localparam int unsigned TICK_HZ    = 256;
    localparam int          PRE_W      = 15;
    localparam logic [14:0] PRE_LAST   = 15'(CRYSTAL_HZ - 1);
    localparam logic [6:0]  TICK_LAST  = 7'(CRYSTAL_HZ / TICK_HZ - 1);
    // filter times in microseconds and in slow ticks (rounded up)
    localparam int unsigned FILT1_US = 3906;
    localparam int unsigned FILT2_US = 15625;
    localparam int unsigned FILT3_US = 31250;
    localparam logic [3:0] FILT1_TICKS = 4'((FILT1_US * TICK_HZ + 999999) / 1000000);
    localparam logic [3:0] FILT2_TICKS = 4'((FILT2_US * TICK_HZ + 999999) / 1000000);
    localparam logic [3:0] FILT3_TICKS = 4'((FILT3_US * TICK_HZ + 999999) / 1000000);
    // sample rates in millihertz and periods in slow ticks
    localparam int unsigned SMP1_MHZ = 2000;
    localparam int unsigned SMP2_MHZ = 1000;
    localparam int unsigned SMP3_MHZ = 250;
    localparam logic [10:0] SMP1_TICKS = 11'(TICK_HZ * 1000 / SMP1_MHZ);
    localparam logic [10:0] SMP2_TICKS = 11'(TICK_HZ * 1000 / SMP2_MHZ);
    localparam logic [10:0] SMP3_TICKS = 11'(TICK_HZ * 1000 / SMP3_MHZ);
    // calendar limits and reset values
    localparam logic [5:0] SEC_LAST  = 6'h3B;
    localparam logic [4:0] HOUR_LAST = 5'h17;
    localparam logic [3:0] MON_LAST  = 4'hC;
    localparam logic [6:0] YEAR_LAST = 7'h63;
    localparam logic [2:0] WDAY_LAST = 3'h6;
    localparam logic [4:0] DATE_RESET = 5'h01;
    localparam logic [3:0] MON_RESET  = 4'h1;
endpackage

/* File: core/rtc_event_alarm_backup.sv */
// clock, calendar, alarm, tamper time stamp and supply switchover behind apb
`timescale 1ns/1ps
`default_nettype none

// Operation
// RULE1 - valid event sets event flag and captures time and date stamp
// RULE2 - event may drive detect output and freeze timekeeping
// RULE3 - event monitor and stamp work on main and backup supply
// RULE4 - selectable sampling rate for the tamper input
// RULE5 - selectable glitch filter before an event is accepted
// RULE6 - high tamper input is an event, low is idle
// RULE7 - enable bit gates tamper input; when off no event
// RULE8 - separate bit keeps detection alive in backup mode
// RULE9 - active-low detect output holds until event flag cleared
// RULE10 - frequency select bits choose interrupt or clock on shared pin
// RULE11 - interrupt mode pulls shared pin low on alarm
// RULE12 - frequency mode outputs selected crystal-derived clock
// RULE13 - alarm fires when all enabled fields match
// RULE14 - alarm flag is pollable and optionally drives interrupt
// RULE15 - repeat mode re-arms alarm after every match
// RULE16 - separate calendar counters with leap years through 2099
// RULE17 - timebase is the 32.768 kHz crystal input
// RULE18 - register bus refuses all transfers in backup mode
// RULE19 - bus speed limit on the host; not relevant to apb
// RULE20 - backup only when below battery-hysteresis and below trip
// RULE21 - filter needs none, 3.9, 15.6 or 31.25 ms high
// RULE22 - input continuous or sampled at 2, 1 or 1/4 Hz
// RULE23 - after full power loss, time halts until a clock write
// RULE24 - host clears event flag by writing status
module rtc_event_alarm_backup (
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // timebase and tamper input
    input  wire logic        crystal_input,
    input  wire logic        tamper_input,
    // supply comparators
    input  wire logic        vdd_below_battery_less_hysteresis,
    input  wire logic        vdd_below_trip_threshold,
    // open-drain pins, enable high pulls low
    output logic             tamper_detect_output_out,
    output logic             tamper_detect_output_oe,
    output logic             interrupt_or_freq_output_out,
    output logic             interrupt_or_freq_output_oe,
    // supply state
    output logic             backup_mode
);
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic        err;
        logic        xtal_q;
        logic [14:0] pre;
        logic [5:0]  sec;
        logic [5:0]  min;
        logic [4:0]  hour;
        logic [4:0]  date;
        logic [3:0]  mon;
        logic [6:0]  year;
        logic [2:0]  wday;
        logic        alarm;
        logic        event_flag;
        logic        fail;
        logic        backup;
        logic [13:0] ctrl;
        logic [5:0]  alm_en;
        logic        armed;
        logic        match_q;
        logic [31:0] alm_time;
        logic [31:0] alm_date;
        logic [31:0] ts_time;
        logic [31:0] ts_date;
        logic        window;
        logic [3:0]  filt_cnt;
        logic [10:0] smp_cnt;
        logic        det_oe;
        logic        pin_oe;
    } rtc_state_type;

    rtc_state_type s;
    rtc_state_type next_s;

    function automatic logic [4:0] rtc_month_days(input logic [3:0] m, input logic [6:0] y);
        logic [4:0] d;
        d = 5'd31;
        if (m == 4'd4 || m == 4'd6 || m == 4'd9 || m == 4'd11) begin
            d = 5'd30;
        end else if (m == 4'd2) begin
            d = (y[1:0] == 2'b00) ? 5'd29 : 5'd28; // [RULE16]
        end
        return d;
    endfunction

    function automatic logic [31:0] rtc_pack_time(input rtc_state_type t);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[rtc_pkg::TF_SEC +: 6]  = t.sec;
        v[rtc_pkg::TF_MIN +: 6]  = t.min;
        v[rtc_pkg::TF_HOUR +: 5] = t.hour;
        return v;
    endfunction

    function automatic logic [31:0] rtc_pack_date(input rtc_state_type t);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[rtc_pkg::DF_DATE +: 5] = t.date;
        v[rtc_pkg::DF_MON +: 4]  = t.mon;
        v[rtc_pkg::DF_WDAY +: 3] = t.wday;
        v[rtc_pkg::DF_YEAR +: 7] = t.year;
        return v;
    endfunction

    logic        xtal_rise;
    logic        tick256;
    logic        tick1;
    logic        run;
    logic        wr;
    logic        raw_evt;
    logic        gated;
    logic        detect;
    logic        match;
    logic [1:0]  filt_sel;
    logic [1:0]  smp_sel;
    logic [3:0]  freq_sel;
    logic [3:0]  need;
    logic [10:0] period;

    always_comb begin
        next_s = s;
        filt_sel = s.ctrl[rtc_pkg::CT_FILT_LO +: 2];
        smp_sel = s.ctrl[rtc_pkg::CT_SMP_LO +: 2];
        freq_sel = s.ctrl[rtc_pkg::CT_FREQ_LO +: 4];
        // timebase from the crystal edge
        xtal_rise = crystal_input & ~s.xtal_q; // [RULE17]
        next_s.xtal_q = crystal_input;
        tick256 = xtal_rise && (s.pre[6:0] == rtc_pkg::TICK_LAST);
        tick1 = xtal_rise && (s.pre == rtc_pkg::PRE_LAST);
        if (xtal_rise) begin
            next_s.pre = s.pre + 15'd1;
        end
        // supply switchover
        next_s.backup = vdd_below_battery_less_hysteresis & vdd_below_trip_threshold; // [RULE20]
        // calendar advance
        run = ~s.fail & ~(s.event_flag & s.ctrl[rtc_pkg::CT_FREEZE]); // [RULE2] [RULE23]
        if (tick1 && run) begin // [RULE16]
            next_s.sec = s.sec + 6'd1;
            if (s.sec == rtc_pkg::SEC_LAST) begin
                next_s.sec = 6'd0;
                next_s.min = s.min + 6'd1;
                if (s.min == rtc_pkg::SEC_LAST) begin
                    next_s.min = 6'd0;
                    next_s.hour = s.hour + 5'd1;
                    if (s.hour == rtc_pkg::HOUR_LAST) begin
                        next_s.hour = 5'd0;
                        next_s.wday = (s.wday == rtc_pkg::WDAY_LAST) ? 3'd0 : s.wday + 3'd1;
                        next_s.date = s.date + 5'd1;
                        if (s.date >= rtc_month_days(s.mon, s.year)) begin
                            next_s.date = rtc_pkg::DATE_RESET;
                            next_s.mon = s.mon + 4'd1;
                            if (s.mon == rtc_pkg::MON_LAST) begin
                                next_s.mon = rtc_pkg::MON_RESET;
                                next_s.year = (s.year == rtc_pkg::YEAR_LAST) ? 7'd0
                                            : s.year + 7'd1;
                            end
                        end
                    end
                end
            end
        end
        // alarm compare, rising edge of the match
        match = (s.alm_en != 6'd0) // [RULE13]
              && (~s.alm_en[rtc_pkg::AE_SEC]  || s.sec  == s.alm_time[rtc_pkg::TF_SEC +: 6])
              && (~s.alm_en[rtc_pkg::AE_MIN]  || s.min  == s.alm_time[rtc_pkg::TF_MIN +: 6])
              && (~s.alm_en[rtc_pkg::AE_HOUR] || s.hour == s.alm_time[rtc_pkg::TF_HOUR +: 5])
              && (~s.alm_en[rtc_pkg::AE_DATE] || s.date == s.alm_date[rtc_pkg::DF_DATE +: 5])
              && (~s.alm_en[rtc_pkg::AE_MON]  || s.mon  == s.alm_date[rtc_pkg::DF_MON +: 4])
              && (~s.alm_en[rtc_pkg::AE_WDAY] || s.wday == s.alm_date[rtc_pkg::DF_WDAY +: 3]);
        next_s.match_q = match;
        // tamper input gating, sampling and filter
        raw_evt = tamper_input & s.ctrl[rtc_pkg::CT_EVT_EN] // [RULE6] [RULE7]
                & (~s.backup | s.ctrl[rtc_pkg::CT_EVT_BAT]); // [RULE3] [RULE8]
        unique case (filt_sel) // [RULE5] [RULE21]
            2'd0: need = 4'd0;
            2'd1: need = rtc_pkg::FILT1_TICKS;
            2'd2: need = rtc_pkg::FILT2_TICKS;
            2'd3: need = rtc_pkg::FILT3_TICKS;
        endcase
        unique case (smp_sel) // [RULE4] [RULE22]
            2'd0: period = 11'd0;
            2'd1: period = rtc_pkg::SMP1_TICKS;
            2'd2: period = rtc_pkg::SMP2_TICKS;
            2'd3: period = rtc_pkg::SMP3_TICKS;
        endcase
        gated = (smp_sel == 2'd0) | s.window;
        detect = gated & raw_evt & (s.filt_cnt >= need);
        if (tick256) begin
            next_s.smp_cnt = s.smp_cnt + 11'd1;
            if (s.smp_cnt + 11'd1 >= period) begin
                next_s.smp_cnt = 11'd0;
                next_s.window = 1'b1;
            end
        end
        if (~gated || ~raw_evt) begin
            next_s.filt_cnt = 4'd0;
        end else if (tick256 && s.filt_cnt < need) begin
            next_s.filt_cnt = s.filt_cnt + 4'd1;
        end
        if (detect || (tick256 && ~raw_evt && s.window)) begin
            next_s.window = 1'b0;
        end
        // apb: one wait cycle, then answer; no bus rate limit here [RULE19]
        wr = psel & penable & pwrite & s.ack & ~s.backup; // [RULE18]
        next_s.ack = psel & penable & ~s.ack;
        next_s.err = 1'b0;
        if (psel && penable && !s.ack) begin
            next_s.rdata = 32'h0000_0000;
            next_s.err = s.backup; // [RULE18]
            if (!s.backup) begin
                unique case (paddr)
                    rtc_pkg::ADDR_SEC:      next_s.rdata = 32'(s.sec);
                    rtc_pkg::ADDR_MIN:      next_s.rdata = 32'(s.min);
                    rtc_pkg::ADDR_HOUR:     next_s.rdata = 32'(s.hour);
                    rtc_pkg::ADDR_DATE:     next_s.rdata = 32'(s.date);
                    rtc_pkg::ADDR_MONTH:    next_s.rdata = 32'(s.mon);
                    rtc_pkg::ADDR_YEAR:     next_s.rdata = 32'(s.year);
                    rtc_pkg::ADDR_WDAY:     next_s.rdata = 32'(s.wday);
                    rtc_pkg::ADDR_STATUS:   next_s.rdata = 32'({s.backup, s.fail, s.event_flag,
                                                               s.alarm}); // [RULE14]
                    rtc_pkg::ADDR_CTRL:     next_s.rdata = 32'(s.ctrl);
                    rtc_pkg::ADDR_ALM_EN:   next_s.rdata = 32'(s.alm_en);
                    rtc_pkg::ADDR_ALM_TIME: next_s.rdata = s.alm_time;
                    rtc_pkg::ADDR_ALM_DATE: next_s.rdata = s.alm_date;
                    rtc_pkg::ADDR_TS_TIME:  next_s.rdata = s.ts_time;
                    rtc_pkg::ADDR_TS_DATE:  next_s.rdata = s.ts_date;
                    default:                next_s.err = 1'b1;
                endcase
            end
        end
        if (wr) begin
            unique case (paddr)
                rtc_pkg::ADDR_SEC:      next_s.sec = pwdata[5:0];
                rtc_pkg::ADDR_MIN:      next_s.min = pwdata[5:0];
                rtc_pkg::ADDR_HOUR:     next_s.hour = pwdata[4:0];
                rtc_pkg::ADDR_DATE:     next_s.date = pwdata[4:0];
                rtc_pkg::ADDR_MONTH:    next_s.mon = pwdata[3:0];
                rtc_pkg::ADDR_YEAR:     next_s.year = pwdata[6:0];
                rtc_pkg::ADDR_WDAY:     next_s.wday = pwdata[2:0];
                rtc_pkg::ADDR_STATUS: begin
                    // write one to clear
                    if (pwdata[rtc_pkg::ST_ALARM]) begin
                        next_s.alarm = 1'b0;
                    end
                    if (pwdata[rtc_pkg::ST_EVENT]) begin
                        next_s.event_flag = 1'b0; // [RULE24]
                    end
                end
                rtc_pkg::ADDR_CTRL:     next_s.ctrl = pwdata[rtc_pkg::CT_W-1:0];
                rtc_pkg::ADDR_ALM_EN: begin
                    next_s.alm_en = pwdata[5:0];
                    next_s.armed = 1'b1;
                end
                rtc_pkg::ADDR_ALM_TIME: begin
                    next_s.alm_time = pwdata;
                    next_s.armed = 1'b1;
                end
                rtc_pkg::ADDR_ALM_DATE: begin
                    next_s.alm_date = pwdata;
                    next_s.armed = 1'b1;
                end
                default: ;
            endcase
            // first write to a clock field restarts timekeeping
            if (paddr <= rtc_pkg::ADDR_WDAY) begin
                next_s.fail = 1'b0; // [RULE23]
                next_s.pre = 15'd0;
            end
        end
        // sets after clears so a simultaneous alarm match wins; the event flag sets only if it was already clear
        if (match && !s.match_q && s.armed) begin
            next_s.alarm = 1'b1; // [RULE13] [RULE14]
            next_s.armed = s.ctrl[rtc_pkg::CT_REPEAT]; // [RULE15]
        end
        if (detect && !s.event_flag) begin
            next_s.event_flag = 1'b1; // [RULE1]
            next_s.ts_time = rtc_pack_time(s); // [RULE1] [RULE3]
            next_s.ts_date = rtc_pack_date(s);
        end
        // pin drivers
        next_s.det_oe = next_s.event_flag & s.ctrl[rtc_pkg::CT_DET_OUT]; // [RULE2] [RULE9]
        if (freq_sel == 4'd0) begin // [RULE10]
            next_s.pin_oe = s.alarm & s.ctrl[rtc_pkg::CT_IRQ_EN]; // [RULE11] [RULE14]
        end else begin
            next_s.pin_oe = ~s.pre[freq_sel - 4'd1]; // [RULE12]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '{date: rtc_pkg::DATE_RESET, mon: rtc_pkg::MON_RESET,
                   ctrl: rtc_pkg::CTRL_RESET, fail: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.rdata;
    assign pready = s.ack;
    assign pslverr = s.ack & s.err;
    assign tamper_detect_output_out = 1'b0;
    assign tamper_detect_output_oe = s.det_oe;
    assign interrupt_or_freq_output_out = 1'b0;
    assign interrupt_or_freq_output_oe = s.pin_oe;
    assign backup_mode = s.backup;

    chk_bus_answer: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready)
        else $error("access not answered after one wait cycle");
    chk_backup_refuse: assert property (@(posedge pclk) disable iff (!presetn) // [RULE18]
        psel && penable && pwrite && paddr == rtc_pkg::ADDR_SEC && s.backup && s.ack
        |=> $stable(s.sec) || $past(tick1))
        else $error("write accepted in backup mode");
    chk_switch_need_both: assert property (@(posedge pclk) disable iff (!presetn) // [RULE20]
        !vdd_below_trip_threshold |=> !backup_mode)
        else $error("backup entered above trip threshold");
    chk_event_gate: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
        !s.ctrl[rtc_pkg::CT_EVT_EN] && !s.event_flag |=> !s.event_flag)
        else $error("event seen while detection disabled");
    chk_event_level: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
        $rose(s.event_flag) |-> $past(tamper_input))
        else $error("event flag set without high input");
    chk_stamp_capture: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
        $rose(s.event_flag) |-> s.ts_time[rtc_pkg::TF_SEC +: 6] == $past(s.sec))
        else $error("time stamp does not hold event second");
    chk_detect_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
        s.event_flag && s.ctrl[rtc_pkg::CT_DET_OUT] ##1 s.event_flag && $stable(s.ctrl)
        |-> tamper_detect_output_oe)
        else $error("detect output released while flag set");
    chk_freeze_time: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
        s.event_flag && s.ctrl[rtc_pkg::CT_FREEZE] && !wr |=> $stable(s.sec))
        else $error("clock advanced while frozen");
    chk_fail_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE23]
        s.fail && !wr |=> $stable(s.sec) && $stable(s.min))
        else $error("clock advanced before first write");
    chk_irq_pin: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
        s.ctrl[rtc_pkg::CT_FREQ_LO +: 4] == 4'd0 && s.ctrl[rtc_pkg::CT_IRQ_EN]
        && s.alarm && !wr ##1 s.alarm |-> interrupt_or_freq_output_oe)
        else $error("interrupt not driven on alarm");
    chk_sec_range: assert property (@(posedge pclk) disable iff (!presetn) // [RULE16]
        tick1 && run && s.sec == rtc_pkg::SEC_LAST && !wr |=> s.sec == 6'd0)
        else $error("seconds did not wrap at 59");
endmodule

`default_nettype wire

/* File: tb/rtc_host_model.sv */
// apb host standing in for the microcontroller
`timescale 1ns/1ps
`default_nettype none
module rtc_host_model (
    // apb master
    input  wire logic        pclk,
    output logic [7:0]       paddr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
    end
    // one transfer; request held until pready is seen high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err, output logic tmo);
        int n;
        tmo = 1'b1;
        rd = 32'h0;
        err = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16 && tmo; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                rd = prdata;
                err = pslverr;
                tmo = 1'b0;
            end
        end
        // released lines stop showing the last value
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_rtc_event_alarm_backup.sv */
// testbench for the clock, calendar, alarm and tamper block
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_event_alarm_backup;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        crystal_input = 1'b0;
    logic        tamper_input = 1'b0;
    logic        bat_cmp = 1'b0;
    logic        trip_cmp = 1'b0;
    logic        det_oe;
    logic        irq_oe;
    logic        backup_mode;
    int          error_cnt = 0;
    int          cmp_count = 0;
    integer      seed = 32'h664c10e0;
    int          m_sec;
    int          i;

    rtc_host_model host (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    rtc_event_alarm_backup dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .crystal_input(crystal_input),
        .tamper_input(tamper_input), .vdd_below_battery_less_hysteresis(bat_cmp),
        .vdd_below_trip_threshold(trip_cmp), .tamper_detect_output_out(),
        .tamper_detect_output_oe(det_oe), .interrupt_or_freq_output_out(),
        .interrupt_or_freq_output_oe(irq_oe), .backup_mode(backup_mode));

    initial begin
        forever #2.5 pclk = ~pclk;
    end
    // fast timebase: one crystal period every two bus clocks
    always @(posedge pclk) crystal_input <= ~crystal_input;

    task automatic tally_and_finish();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic eexp);
        logic [31:0] rd;
        logic        e;
        logic        t;
        host.xfer(w, a, d, rd, e, t);
        if (t) begin
            error_cnt++;
            tally_and_finish();
        end
        if (!w)
            chk(rd, exp);
        chk({31'h0, e}, {31'h0, eexp});
    endtask
    task automatic wait_for(input logic sel, input logic lvl, input int lim);
        int n;
        for (n = 0; n < lim; n++) begin
            @(posedge pclk);
            if ((sel ? irq_oe : det_oe) === lvl)
                return;
        end
        error_cnt++;
        tally_and_finish();
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        acc(0, rtc_pkg::ADDR_STATUS, 0, 32'h4, 0);
        acc(0, rtc_pkg::ADDR_CTRL, 0, 32'h0, 0);
        acc(0, 8'h3C, 0, 32'h0, 1);
        m_sec = $unsigned($random(seed)) % 60;
        acc(1, rtc_pkg::ADDR_SEC, m_sec, 0, 0);
        acc(0, rtc_pkg::ADDR_STATUS, 0, 32'h0, 0);
        acc(0, rtc_pkg::ADDR_SEC, 0, m_sec, 0);
        for (i = 0; i < 4; i++) begin
            bat_cmp <= i[0];
            trip_cmp <= i[1];
            repeat (3) @(posedge pclk);
            chk({31'h0, backup_mode}, {31'h0, i == 3});
            acc(0, rtc_pkg::ADDR_SEC, 0, (i == 3) ? 0 : m_sec, i == 3);
        end
        acc(1, rtc_pkg::ADDR_SEC, (m_sec + 1) % 60, 0, 1);
        bat_cmp <= 1'b0;
        trip_cmp <= 1'b0;
        acc(0, rtc_pkg::ADDR_SEC, 0, m_sec, 0);
        // gated input: high level but detection off
        tamper_input <= 1'b1;
        repeat (600) @(posedge pclk);
        chk({31'h0, det_oe}, 32'h0);
        acc(0, rtc_pkg::ADDR_STATUS, 0, 32'h0, 0);
        acc(1, rtc_pkg::ADDR_CTRL, 32'h19, 0, 0);
        wait_for(0, 1, 2000);
        acc(0, rtc_pkg::ADDR_STATUS, 0, 32'h2, 0);
        acc(0, rtc_pkg::ADDR_TS_TIME, 0, m_sec, 0);
        tamper_input <= 1'b0;
        acc(1, rtc_pkg::ADDR_STATUS, 32'h2, 0, 0);
        wait_for(0, 0, 8);
        acc(0, rtc_pkg::ADDR_STATUS, 0, 32'h0, 0);
        // event in backup, detection kept alive there, freeze on
        acc(1, rtc_pkg::ADDR_CTRL, 32'hF, 0, 0);
        bat_cmp <= 1'b1;
        trip_cmp <= 1'b1;
        repeat (2) @(posedge pclk);
        tamper_input <= 1'b1;
        wait_for(0, 1, 8);
        bat_cmp <= 1'b0;
        trip_cmp <= 1'b0;
        tamper_input <= 1'b0;
        acc(0, rtc_pkg::ADDR_STATUS, 0, 32'h2, 0);
        acc(1, rtc_pkg::ADDR_STATUS, 32'h2, 0, 0);
        // one second before midnight, alarm on seconds equal to zero
        acc(1, rtc_pkg::ADDR_CTRL, 32'h100, 0, 0);
        // time first, so a zero second cannot match before arming
        acc(1, rtc_pkg::ADDR_MIN, 32'h3B, 0, 0);
        acc(1, rtc_pkg::ADDR_HOUR, 32'h17, 0, 0);
        acc(1, rtc_pkg::ADDR_SEC, 32'h3B, 0, 0);
        acc(1, rtc_pkg::ADDR_ALM_EN, 32'h1, 0, 0);
        acc(1, rtc_pkg::ADDR_ALM_TIME, 32'h0, 0, 0);
        wait_for(1, 1, 70000);
        acc(0, rtc_pkg::ADDR_STATUS, 0, 32'h1, 0);
        acc(0, rtc_pkg::ADDR_SEC, 0, (59 + 1) % 60, 0);
        acc(0, rtc_pkg::ADDR_HOUR, 0, (23 + 1) % 24, 0);
        acc(0, rtc_pkg::ADDR_DATE, 0, 32'h2, 0);
        // shared pin as clock: select 2, four bus clocks per level
        acc(1, rtc_pkg::ADDR_CTRL, 32'h800, 0, 0);
        wait_for(1, 0, 8);
        wait_for(1, 1, 5);
        wait_for(1, 0, 5);
        tally_and_finish();
    end
endmodule
`default_nettype wire
